// [logic/fpwc_regs.vh]
`ifndef FPWC_REGS_VH
`define FPWC_REGS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FPWC_REG_STATUS      4'h0
`define FPWC_REG_CONTROL     4'h4
`define FPWC_REG_INFO        4'h8

// ----------------------------------------
// status word fields
// ----------------------------------------
`define FPWC_SW_INVALID      0
`define FPWC_SW_DENORM       1
`define FPWC_SW_ZERODIV      2
`define FPWC_SW_OVERFLOW     3
`define FPWC_SW_UNDERFLOW    4
`define FPWC_SW_INEXACT      5
`define FPWC_SW_STACK_FAULT  6
`define FPWC_SW_SUMMARY      7
`define FPWC_SW_COND_ONE     9
`define FPWC_NUM_CLASSES     6

// ----------------------------------------
// reset and initialise values
// ----------------------------------------
`define FPWC_CW_RESET        16'h037F
`define FPWC_SW_RESET        16'h0000
`define FPWC_CW_MASK_BITS    16'h003F
`define FPWC_MASK_RESET      6'h3F

// ----------------------------------------
// operation codes
// ----------------------------------------
`define FPWC_OP_NOP          5'h00
`define FPWC_OP_CHECK        5'h01
`define FPWC_OP_ARITH        5'h02
`define FPWC_OP_LOAD_VALUE   5'h03
`define FPWC_OP_STORE_VALUE  5'h04
`define FPWC_OP_TRUNC_STORE  5'h05
`define FPWC_OP_LOAD_CW      5'h06
`define FPWC_OP_STORE_CW     5'h07
`define FPWC_OP_STORE_SW     5'h08
`define FPWC_OP_SAVE         5'h09
`define FPWC_OP_RESTORE      5'h0A
`define FPWC_OP_XSAVE        5'h0B
`define FPWC_OP_XRESTORE     5'h0C
`define FPWC_OP_INIT         5'h0D
`define FPWC_OP_CLEAR_EXC    5'h0E
`define FPWC_OP_LEG_INT_EN   5'h0F
`define FPWC_OP_LEG_INT_DIS  5'h10
`define FPWC_OP_LEG_PROTMODE 5'h11
`define FPWC_OP_MISC_NONARITH 5'h12

// ----------------------------------------
// operand formats
// ----------------------------------------
`define FPWC_FMT_REG         2'h0
`define FPWC_FMT_SINGLE      2'h1
`define FPWC_FMT_DOUBLE      2'h2
`define FPWC_FMT_EXTENDED    2'h3

`endif

// [logic/fpwc_classify.v]
`include "fpwc_regs.vh"

module fpwc_classify (
   input  wire [4:0] op,
   input  wire [1:0] fmt,
   input  wire       nowait,
   output reg        is_arith,
   output reg        is_waiting,
   output reg        is_legacy
);

   // ----------------------------------------
   // arithmetic versus non-arithmetic
   // ----------------------------------------
   always @* begin
      case (op)
         `FPWC_OP_ARITH,
         `FPWC_OP_TRUNC_STORE: is_arith = 1'b1;
         `FPWC_OP_LOAD_VALUE,
         `FPWC_OP_STORE_VALUE: is_arith = (fmt == `FPWC_FMT_SINGLE) ||
                                          (fmt == `FPWC_FMT_DOUBLE);
         default:              is_arith = 1'b0;
      endcase
   end

   // ----------------------------------------
   // waiting form and legacy detection
   // ----------------------------------------
   always @* begin
      case (op)
         `FPWC_OP_STORE_CW,
         `FPWC_OP_STORE_SW,
         `FPWC_OP_SAVE,
         `FPWC_OP_INIT,
         `FPWC_OP_CLEAR_EXC:    is_waiting = ~nowait;
         `FPWC_OP_LEG_INT_EN,
         `FPWC_OP_LEG_INT_DIS,
         `FPWC_OP_LEG_PROTMODE: is_waiting = 1'b0;
         default:               is_waiting = 1'b1;
      endcase
      is_legacy = (op == `FPWC_OP_LEG_INT_EN) || (op == `FPWC_OP_LEG_INT_DIS) ||
                  (op == `FPWC_OP_LEG_PROTMODE);
   end

endmodule

// [logic/fpwc_top.v]
`include "fpwc_regs.vh"

module fpwc_top (
   input  wire        clock,
   input  wire        nrst,
   input  wire        issue_valid,
   output wire        issue_ready,
   input  wire [4:0]  issue_op,
   input  wire [1:0]  issue_fmt,
   input  wire        issue_nowait,
   input  wire [31:0] issue_data,
   output reg         done,
   output reg  [31:0] result_data,
   output reg         result_arith,
   output wire        handler_req,
   input  wire        exc_valid,
   input  wire [5:0]  exc_class,
   input  wire        exc_stack,
   input  wire        exc_stack_over,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output wire [15:0] status_word,
   output wire [15:0] control_word
);

   localparam [1:0] ST_RUN   = 2'b01;
   localparam [1:0] ST_STALL = 2'b10;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   reg rst_meta;
   reg rst_n;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------
   // issue state
   // ----------------------------------------
   reg  [1:0]  state;
   reg  [1:0]  next_state;

   // ----------------------------------------
   // exception and control state
   // ----------------------------------------
   reg  [5:0]  exc_flags;
   reg  [5:0]  next_exc_flags;
   reg  [5:0]  exc_masks;
   reg  [5:0]  next_exc_masks;
   reg  [15:0] cw_other;
   reg  [15:0] next_cw_other;
   reg         stack_fault_flag;
   reg         next_stack_fault_flag;
   reg         cond_code_one;
   reg         next_cond_code_one;

   // ----------------------------------------
   // bookkeeping
   // ----------------------------------------
   reg         last_arith;
   reg         bus_ack;
   reg  [4:0]  last_op;
   reg  [7:0]  legacy_count;
   reg  [7:0]  stall_count;

   // ----------------------------------------
   // internal nets
   // ----------------------------------------
   wire        is_arith;
   wire        is_waiting;
   wire        is_legacy;
   wire        pending;
   wire        exception_summary_flag;
   wire        take;
   wire        take_effect;
   wire        bus_req;
   wire        bus_wr;
   wire [5:0]  bus_clr;
   reg  [5:0]  raised;
   wire        raised_stack;

   fpwc_classify u_classify (
      .op         (issue_op),
      .fmt        (issue_fmt),
      .nowait     (issue_nowait),
      .is_arith   (is_arith),
      .is_waiting (is_waiting),
      .is_legacy  (is_legacy)
   );

   // ----------------------------------------
   // summary and pending check
   // ----------------------------------------
   function [15:0] pack_sw;
      input [5:0] flags;
      input       sf;
      input       es;
      input       c1;
      begin
         pack_sw = 16'h0000;
         pack_sw[5:0] = flags;
         pack_sw[`FPWC_SW_STACK_FAULT] = sf;
         pack_sw[`FPWC_SW_SUMMARY] = es;
         pack_sw[`FPWC_SW_COND_ONE] = c1;
      end
   endfunction

   assign exception_summary_flag = |(exc_flags & ~exc_masks);
   assign pending      = exception_summary_flag;

   // ----------------------------------------
   // status and control words
   // ----------------------------------------
   assign status_word  = pack_sw(exc_flags, stack_fault_flag, exception_summary_flag, cond_code_one);
   assign control_word = (cw_other & ~`FPWC_CW_MASK_BITS) | {10'h000, exc_masks};

   // ----------------------------------------
   // issue handshake
   // ----------------------------------------
   assign issue_ready  = (state == ST_RUN) && !(is_waiting && pending);
   assign handler_req  = (state == ST_STALL);
   assign take         = issue_valid && issue_ready;
   assign take_effect  = take && !is_legacy;

   // ----------------------------------------
   // diagnostic word
   // ----------------------------------------
   function [31:0] info_word;
      input [7:0] stalls;
      input [7:0] legacies;
      input [4:0] op;
      input       arith;
      input [1:0] st;
      begin
         info_word = 32'h00000000;
         info_word[31:24] = stalls;
         info_word[23:16] = legacies;
         info_word[12:8]  = op;
         info_word[2]     = arith;
         info_word[1:0]   = st;
      end
   endfunction

   // ----------------------------------------
   // exception reports, kept only after an arithmetic instruction (last_arith) except stack faults
   // ----------------------------------------
   assign raised_stack = exc_valid && exc_stack;
   always @* begin
      if (!exc_valid) begin
         raised = 6'h00;
      end else if (last_arith) begin
         raised = exc_class;
      end else begin
         raised = 6'h00;
      end
   end

   // ----------------------------------------
   // register bus decode
   // ----------------------------------------
   assign bus_req      = avs_read || avs_write;
   assign bus_wr       = avs_write && bus_ack && (avs_address == `FPWC_REG_STATUS) && avs_byteenable[0];
   assign bus_clr      = bus_wr ? avs_writedata[5:0] : 6'h00;
   assign avs_waitrequest = bus_req && !bus_ack;

   // ----------------------------------------
   // instruction effects
   // ----------------------------------------
   always @* begin
      next_exc_flags        = exc_flags;
      next_exc_masks        = exc_masks;
      next_cw_other         = cw_other;
      next_stack_fault_flag = stack_fault_flag;
      next_cond_code_one    = cond_code_one;
      if (take_effect) begin
         case (issue_op)
            `FPWC_OP_LOAD_CW: begin
               next_exc_masks = issue_data[5:0];
               next_cw_other  = issue_data[15:0];
            end
            `FPWC_OP_RESTORE,
            `FPWC_OP_XRESTORE: begin
               next_exc_masks        = issue_data[5:0];
               next_cw_other         = issue_data[15:0];
               next_exc_flags        = issue_data[21:16];
               next_stack_fault_flag = issue_data[16 + `FPWC_SW_STACK_FAULT];
               next_cond_code_one    = issue_data[16 + `FPWC_SW_COND_ONE];
            end
            `FPWC_OP_SAVE,
            `FPWC_OP_INIT: begin
               next_exc_masks        = `FPWC_MASK_RESET;
               next_cw_other         = `FPWC_CW_RESET;
               next_exc_flags        = 6'h00;
               next_stack_fault_flag = 1'b0;
               next_cond_code_one    = 1'b0;
            end
            `FPWC_OP_CLEAR_EXC: begin
               next_exc_flags        = 6'h00;
               next_stack_fault_flag = 1'b0;
            end
            default: begin
               next_exc_flags = exc_flags;
            end
         endcase
      end
      next_exc_flags = next_exc_flags & ~bus_clr;
      if (bus_wr && avs_writedata[`FPWC_SW_STACK_FAULT]) begin
         next_stack_fault_flag = 1'b0;
      end
      next_exc_flags = next_exc_flags | raised;
      if (raised_stack) begin
         next_exc_flags[`FPWC_SW_INVALID] = 1'b1;
         next_stack_fault_flag            = 1'b1;
         next_cond_code_one               = exc_stack_over;
      end
   end

   // ----------------------------------------
   // issue state machine
   // ----------------------------------------
   always @* begin
      case (state)
         ST_RUN: begin
            if (issue_valid && is_waiting && pending) begin
               next_state = ST_STALL;
            end else begin
               next_state = ST_RUN;
            end
         end
         ST_STALL: begin
            if (!pending) begin
               next_state = ST_RUN;
            end else begin
               next_state = ST_STALL;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state            <= ST_RUN;
         exc_flags        <= 6'h00;
         exc_masks        <= `FPWC_MASK_RESET;
         cw_other         <= `FPWC_CW_RESET;
         stack_fault_flag <= 1'b0;
         cond_code_one    <= 1'b0;
         last_arith       <= 1'b0;
         last_op          <= `FPWC_OP_NOP;
         legacy_count     <= 8'h00;
         stall_count      <= 8'h00;
      end else begin
         state            <= next_state;
         exc_flags        <= next_exc_flags;
         exc_masks        <= next_exc_masks;
         cw_other         <= next_cw_other;
         stack_fault_flag <= next_stack_fault_flag;
         cond_code_one    <= next_cond_code_one;
         if (take_effect) begin
            last_arith <= is_arith;
            last_op    <= issue_op;
         end
         if (take && is_legacy) begin
            legacy_count <= legacy_count + 8'h01;
         end
         if (state == ST_RUN && next_state == ST_STALL) begin
            stall_count <= stall_count + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // completion and stored words
   // ----------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done         <= 1'b0;
         result_data  <= 32'h00000000;
         result_arith <= 1'b0;
      end else begin
         done <= take;
         if (take) begin
            result_arith <= is_arith;
            case (issue_op)
               `FPWC_OP_STORE_CW: result_data <= {16'h0000, control_word};
               `FPWC_OP_STORE_SW: result_data <= {16'h0000, status_word};
               `FPWC_OP_SAVE,
               `FPWC_OP_XSAVE:    result_data <= {status_word, control_word};
               default:           result_data <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack      <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         bus_ack <= bus_req && !bus_ack;
         if (avs_read && !bus_ack) begin
            case (avs_address)
               `FPWC_REG_STATUS:  avs_readdata <= {16'h0000, status_word};
               `FPWC_REG_CONTROL: avs_readdata <= {16'h0000, control_word};
               `FPWC_REG_INFO:    avs_readdata <= info_word(stall_count, legacy_count, last_op, last_arith, state);
               default:           avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// [bench/fpwc_props.sv]
`include "fpwc_regs.vh"

module fpwc_props (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic        issue_valid,
   input wire logic        issue_ready,
   input wire logic [4:0]  issue_op,
   input wire logic [1:0]  issue_fmt,
   input wire logic        issue_nowait,
   input wire logic        done,
   input wire logic        result_arith,
   input wire logic        handler_req,
   input wire logic        exc_valid,
   input wire logic        exc_stack,
   input wire logic        exc_stack_over,
   input wire logic        avs_write,
   input wire logic [15:0] status_word,
   input wire logic [15:0] control_word
);
   wire take = issue_valid && issue_ready;
   wire nw_op = issue_nowait && (issue_op == `FPWC_OP_STORE_CW || issue_op == `FPWC_OP_STORE_SW ||
      issue_op == `FPWC_OP_SAVE || issue_op == `FPWC_OP_INIT || issue_op == `FPWC_OP_CLEAR_EXC);
   wire leg_op = issue_op == `FPWC_OP_LEG_INT_EN || issue_op == `FPWC_OP_LEG_INT_DIS ||
      issue_op == `FPWC_OP_LEG_PROTMODE;
   wire mem_sd = issue_fmt == `FPWC_FMT_SINGLE || issue_fmt == `FPWC_FMT_DOUBLE;
   wire exp_ar = issue_op == `FPWC_OP_ARITH || issue_op == `FPWC_OP_TRUNC_STORE ||
      ((issue_op == `FPWC_OP_LOAD_VALUE || issue_op == `FPWC_OP_STORE_VALUE) && mem_sd);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   a_summary_exact: assert property (status_word[7] == |(status_word[5:0] & ~control_word[5:0]))
      else $error("summary flag wrong");
   a_stall_refuse: assert property (issue_valid && !nw_op && !leg_op && status_word[7] |-> !issue_ready)
      else $error("waiting op taken while pending");
   a_nowait_pass: assert property (issue_valid && nw_op && !handler_req |-> issue_ready)
      else $error("non-waiting op refused");
   a_handler_rise: assert property (issue_valid && !issue_ready && status_word[7] && !avs_write |=> handler_req)
      else $error("no handler request on stall");
   a_done_after: assert property (take |=> done)
      else $error("done missing after take");
   a_done_idle: assert property (!take |=> !done)
      else $error("done without take");
   a_legacy_still: assert property (take && leg_op && !exc_valid && !avs_write |=> $stable(control_word)
      && $stable(status_word))
      else $error("legacy op changed state");
   a_stack_sets: assert property (exc_valid && exc_stack |=> status_word[0] && status_word[6]
      && status_word[9] == $past(exc_stack_over))
      else $error("stack fault bits wrong");
   a_class_out: assert property (take && !leg_op |=> result_arith == $past(exp_ar))
      else $error("arithmetic class wrong");

   cover property (handler_req);
   cover property (exc_valid && exc_stack);
   cover property (take && nw_op && status_word[7]);
endmodule

bind fpwc_top fpwc_props u_props (.clock, .nrst, .issue_valid, .issue_ready, .issue_op, .issue_fmt, .issue_nowait,
   .done, .result_arith, .handler_req, .exc_valid, .exc_stack, .exc_stack_over, .avs_write, .status_word,
   .control_word);

// [bench/fpwc_pipe_model.sv]
module fpwc_pipe_model (
   input  wire logic        clock,
   input  wire logic        issue_ready,
   output logic             issue_valid,
   output logic [4:0]       issue_op,
   output logic [1:0]       issue_fmt,
   output logic             issue_nowait,
   output logic [31:0]      issue_data,
   output logic             exc_valid,
   output logic [5:0]       exc_class,
   output logic             exc_stack,
   output logic             exc_stack_over
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {issue_valid, issue_op, issue_fmt, issue_nowait, issue_data} = '0;
      {exc_valid, exc_class, exc_stack, exc_stack_over} = '0;
   end
   // offer an instruction, held until taken
   task automatic start(input logic [4:0] o, input logic [1:0] f, input logic nw, input logic [31:0] d);
      issue_valid <= 1'b1;
      issue_op <= o;
      issue_fmt <= f;
      issue_nowait <= nw;
      issue_data <= d;
   endtask
   task automatic finish(output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      while (n < 200 && !ok) begin
         @(posedge clock);
         ok = issue_ready;
         n++;
      end
      issue_valid <= 1'b0;
      issue_data <= ~issue_data;
   endtask
   // one-cycle exception report for the last instruction
   task automatic report(input logic [5:0] c, input logic s, input logic ov);
      exc_valid <= 1'b1;
      exc_class <= c;
      exc_stack <= s;
      exc_stack_over <= ov;
      @(posedge clock);
      exc_valid <= 1'b0;
      exc_class <= ~c;
      exc_stack_over <= ~ov;
   endtask
endmodule

// [bench/test_fp_exception_wait_control.sv]
`include "fpwc_regs.vh"

module test_fp_exception_wait_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, nrst, avs_read, avs_write, issue_valid, issue_ready, issue_nowait, done, result_arith;
   logic        handler_req, exc_valid, exc_stack, exc_stack_over, avs_waitrequest, ok;
   logic [4:0]  issue_op;
   logic [1:0]  issue_fmt;
   logic [5:0]  exc_class;
   logic [3:0]  avs_address;
   logic [31:0] issue_data, result_data, avs_writedata, avs_readdata, rd;
   logic [15:0] status_word, control_word;
   int          failures = 0, checks_done = 0, cycles = 0;
   logic [4:0]  cop [15] = '{`FPWC_OP_ARITH, `FPWC_OP_LOAD_VALUE, `FPWC_OP_LOAD_VALUE, `FPWC_OP_LOAD_VALUE,
      `FPWC_OP_LOAD_VALUE, `FPWC_OP_STORE_VALUE, `FPWC_OP_STORE_VALUE, `FPWC_OP_STORE_VALUE, `FPWC_OP_STORE_VALUE,
      `FPWC_OP_TRUNC_STORE, `FPWC_OP_MISC_NONARITH, `FPWC_OP_CHECK, `FPWC_OP_NOP, `FPWC_OP_LOAD_CW,
      `FPWC_OP_CLEAR_EXC};
   logic [1:0]  cfm [15] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
   logic [14:0] car = 15'b101100110100000;

   fpwc_top dut (.clock, .nrst, .issue_valid, .issue_ready, .issue_op, .issue_fmt, .issue_nowait, .issue_data,
      .done, .result_data, .result_arith, .handler_req, .exc_valid, .exc_class, .exc_stack, .exc_stack_over,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
      .avs_waitrequest, .status_word, .control_word);
   fpwc_pipe_model pipe (.clock, .issue_ready, .issue_valid, .issue_op, .issue_fmt, .issue_nowait, .issue_data,
      .exc_valid, .exc_class, .exc_stack, .exc_stack_over);

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures++;
         end_sim();
      end
   end
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do begin
         @(posedge clock);
      end while (avs_waitrequest);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~wd;
      @(posedge clock);
   endtask
   task automatic tail(input logic [31:0] er, input logic ea);
      pipe.finish(ok);
      @(posedge clock);
      chk(ok, 1'b1);
      chk(done, 1'b1);
      chk(result_data, er);
      chk(result_arith, ea);
   endtask
   task automatic op(input logic [4:0] o, input logic nw, input logic [31:0] d, input logic [31:0] er);
      pipe.start(o, 2'h0, nw, d);
      tail(er, o == `FPWC_OP_ARITH);
   endtask
   task automatic rep(input logic [5:0] c, input logic s, input logic ov, input logic [15:0] esw);
      pipe.report(c, s, ov);
      @(posedge clock);
      chk(status_word, esw);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      chk(control_word, 16'h037F);
      for (int i = 0; i < 15; i++) begin
         pipe.start(cop[i], cfm[i], 1'b0, 32'h0000037F);
         tail(32'h0, car[14-i]);
      end
      rep(6'h04, 1'b0, 1'b0, 16'h0000);
      rep(6'h00, 1'b1, 1'b0, 16'h0041);
      bus(1'b1, 4'h0, 32'h00000041, rd);
      op(`FPWC_OP_ARITH, 1'b0, 32'h0, 32'h0);
      rep(6'h3F, 1'b0, 1'b0, 16'h003F);
      bus(1'b0, 4'h0, 32'h0, rd);
      chk(rd, 32'h0000003F);
      bus(1'b1, 4'hC, 32'h0000FFFF, rd);
      bus(1'b0, 4'hC, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b1, 4'h4, 32'h0, rd);
      chk(control_word, 16'h037F);
      op(`FPWC_OP_LOAD_CW, 1'b0, 32'h0000037E, 32'h0);
      chk(status_word, 16'h00BF);
      op(`FPWC_OP_STORE_SW, 1'b1, 32'h0, 32'h000000BF);
      op(`FPWC_OP_STORE_CW, 1'b1, 32'h0, 32'h0000037E);
      op(`FPWC_OP_SAVE, 1'b1, 32'h0, 32'h00BF037E);
      op(`FPWC_OP_RESTORE, 1'b0, 32'h0000037E, 32'h0);
      op(`FPWC_OP_ARITH, 1'b0, 32'h0, 32'h0);
      rep(6'h01, 1'b0, 1'b0, 16'h0081);
      pipe.start(`FPWC_OP_ARITH, 2'h0, 1'b0, 32'h0);
      repeat (3) @(posedge clock);
      chk(issue_ready, 1'b0);
      chk(handler_req, 1'b1);
      bus(1'b1, 4'h0, 32'h00000001, rd);
      tail(32'h0, 1'b1);
      rep(6'h00, 1'b1, 1'b1, 16'h02C1);
      op(`FPWC_OP_INIT, 1'b1, 32'h0, 32'h0);
      chk(control_word, 16'h037F);
      bus(1'b1, 4'h0, 32'h0000007F, rd);
      rep(6'h00, 1'b1, 1'b0, 16'h0041);
      op(`FPWC_OP_XRESTORE, 1'b0, 32'h0000037B, 32'h0);
      op(`FPWC_OP_XSAVE, 1'b0, 32'h0, 32'h0000037B);
      for (int i = 0; i < 3; i++) begin
         pipe.start(5'(`FPWC_OP_LEG_INT_EN + i), 2'h0, 1'b0, 32'h0);
         pipe.finish(ok);
         chk(ok, 1'b1);
         @(posedge clock);
         chk({status_word, control_word}, 32'h0000037B);
      end
      bus(1'b0, 4'h8, 32'h0, rd);
      chk(rd[23:16], 8'h03);
      op(`FPWC_OP_ARITH, 1'b0, 32'h0, 32'h0);
      rep(6'h04, 1'b0, 1'b0, 16'h0084);
      end_sim();
   end
endmodule
